// File: hdl/csif_defines.vh
`ifndef CSIF_DEFINES_VH
`define CSIF_DEFINES_VH

// ----------------------------------------------------------------
// register word addresses
// ----------------------------------------------------------------
`define CSIF_ADDR_FILTCTL 3'h0
`define CSIF_ADDR_VECTOR 3'h1
`define CSIF_ADDR_FIFOCTL 3'h2
`define CSIF_ADDR_FIFOSTAT 3'h3
`define CSIF_ADDR_FLAGS 3'h4
`define CSIF_ADDR_ENABLES 3'h5

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CSIF_POS_HITNUM 8
`define CSIF_POS_SIZE 13
`define CSIF_POS_WRPTR 8
`define CSIF_POS_STATE 8
`define CSIF_BIT_IVR 7
`define CSIF_BIT_WAKE 6
`define CSIF_BIT_ERR 5
`define CSIF_BIT_FIFO 3
`define CSIF_BIT_RBOV 2
`define CSIF_BIT_RXB 1
`define CSIF_BIT_TB 0
`define CSIF_FLAG_MASK 8'hef

// ----------------------------------------------------------------
// codes, limits and reset values
// ----------------------------------------------------------------
`define CSIF_CODE_NONE 7'h40
`define CSIF_CODE_ERR 7'h41
`define CSIF_CODE_WAKE 7'h42
`define CSIF_CODE_OVF 7'h43
`define CSIF_CODE_FIFO 7'h44
`define CSIF_DNC_MAX 5'h11
`define CSIF_HITNUM_MAX 5'h0f
`define CSIF_SIZE_RSVD 3'h7
`define CSIF_RST_DNC 5'h00
`define CSIF_RST_HITNUM 5'h00
`define CSIF_RST_SIZE 3'h0
`define CSIF_RST_START 5'h00
`define CSIF_RST_PTR 6'h00
`define CSIF_RST_FLAGS 8'h00
`define CSIF_RST_EN 8'h00
`define CSIF_RST_STATE 6'h00

`endif

// File: hdl/csif_regs.v
// Summary of operation
// - count zero means no data byte compare
// - counts 1..17 extend compare, 18..31 invalid
// - read-only matched filter number, 0..15 only
// - non-buffer interrupt codes 0x40..0x44
// - buffer interrupt codes are buffer index 0..15
// - buffer-size code selects 4..32 DMA buffers
// - writable fifo start buffer, 0..31
// - read-only fifo write pointer, buffers 0..31
// - read-only fifo read pointer in low bits
// - bus-off and error-passive status bits 13..11
// - warning status bits 10..8, bit 8 either
// - error flag set on any error-state condition
// - invalid message flag, software clears only
// - wake-up flag set on bus activity
// - almost-full flag when fifo nearly full
// - overflow flag when target buffer occupied
// - rx and tx buffer flags on buffer events
// - unimplemented bits read zero, ignore writes
// - wake-up still flagged in disable mode
//
// Chosen here: the strobed register port and the placing of the registers.
module csif_regs #(
   parameter DATA_W = 16
) (
   input wire clk_i,
   input wire rst_i,
   input wire [2:0] addr_i,
   input wire [DATA_W-1:0] wr_data_i,
   input wire wr_i,
   input wire rd_i,
   output reg [DATA_W-1:0] rd_data_o,
   input wire can_rx_i,
   input wire disable_mode_i,
   input wire [4:0] data_byte_compare_count_i,
   input wire filter_hit_valid_i,
   input wire [4:0] filter_hit_i,
   input wire tx_buf_event_i,
   input wire [2:0] tx_buf_index_i,
   input wire rx_buf_event_i,
   input wire [3:0] rx_buf_index_i,
   input wire invalid_msg_i,
   input wire rx_overflow_i,
   input wire fifo_store_i,
   input wire fifo_read_i,
   input wire tx_bus_off_i,
   input wire tx_err_passive_i,
   input wire rx_err_passive_i,
   input wire tx_warn_i,
   input wire rx_warn_i,
   output reg irq_o,
   output reg data_compare_en_o,
   output reg [4:0] data_compare_bits_o,
   output reg dnc_invalid_o,
   output reg [5:0] dma_buffer_count_o,
   output reg [4:0] fifo_start_buffer_o,
   output reg [5:0] fifo_write_pointer_o,
   output reg fifo_store_ok_o
);

`include "csif_defines.vh"

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   reg [4:0] dnc_r;
   reg [4:0] matched_filter_number_r;
   reg [6:0] pending_source_code_r;
   reg [6:0] pending_source_code_nxt;
   reg [2:0] dma_buffer_count_select_r;
   reg [4:0] fifo_start_buffer_r;
   reg [5:0] fifo_write_pointer_r;
   reg [5:0] fifo_read_pointer_r;
   reg [5:0] fifo_occ_r;
   reg [5:0] state_r;
   reg [5:0] state_prev_r;
   reg [7:0] flags_r;
   reg [7:0] flags_nxt;
   reg [7:0] en_r;
   reg [15:0] buf_pend_r;
   reg [15:0] buf_pend_nxt;
   reg rx_meta_r;
   reg rx_sync_r;
   reg rx_prev_r;
   reg [5:0] dma_count;
   reg [5:0] fifo_last;
   reg [5:0] fifo_cap;
   reg [DATA_W-1:0] rd_mux;
   integer i;

   wire fifo_usable = ({1'b0, fifo_start_buffer_r} <= fifo_last);
   wire fifo_full = (fifo_occ_r >= fifo_cap);
   wire store_ok = fifo_store_i & fifo_usable & ~fifo_full & ~disable_mode_i;
   wire store_bad = fifo_store_i & ~store_ok & ~disable_mode_i;
   wire read_ok = fifo_read_i & (fifo_occ_r != 6'h00);
   wire wr_flags = wr_i & (addr_i == `CSIF_ADDR_FLAGS);
   wire wr_fifoctl = wr_i & (addr_i == `CSIF_ADDR_FIFOCTL);
   wire [5:0] state_now = {tx_bus_off_i, tx_err_passive_i, rx_err_passive_i,
                           tx_warn_i, rx_warn_i, tx_warn_i | rx_warn_i};
   wire wake_evt = rx_prev_r & ~rx_sync_r;
   wire live = ~disable_mode_i;

   // ----------------------------------------------------------------
   // decodes of buffer geometry
   // ----------------------------------------------------------------
   // buffer count decode
   always @* begin
      case (dma_buffer_count_select_r)
         3'h0: dma_count = 6'd4;
         3'h1: dma_count = 6'd6;
         3'h2: dma_count = 6'd8;
         3'h3: dma_count = 6'd12;
         3'h4: dma_count = 6'd16;
         3'h5: dma_count = 6'd24;
         3'h6: dma_count = 6'd32;
         default: dma_count = 6'd4;
      endcase
      fifo_last = dma_count - 6'd1;
      // a start beyond the last buffer leaves no fifo at all
      if (fifo_usable) begin
         fifo_cap = fifo_last - {1'b0, fifo_start_buffer_r} + 6'd1;
      end else begin
         fifo_cap = 6'd0;
      end
   end

   // ----------------------------------------------------------------
   // bus activity synchroniser
   // ----------------------------------------------------------------
   // the rx pin is asynchronous; only rx_sync_r and its delayed copy rx_prev_r feed logic
   always @(posedge clk_i) begin
      if (rst_i) begin
         rx_meta_r <= 1'b1;
         rx_sync_r <= 1'b1;
         rx_prev_r <= 1'b1;
      end else begin
         rx_meta_r <= can_rx_i;
         rx_sync_r <= rx_meta_r;
         rx_prev_r <= rx_sync_r;
      end
   end

   // ----------------------------------------------------------------
   // flag set and clear
   // ----------------------------------------------------------------
   // set wins over a software clear in the same cycle
   always @* begin
      flags_nxt = flags_r;
      if (wr_flags) begin
         flags_nxt = flags_r & wr_data_i[7:0];
      end
      if (wake_evt) begin
         flags_nxt[`CSIF_BIT_WAKE] = 1'b1;
      end
      // other sources frozen while disabled, pending flags kept
      if (live) begin
         if (invalid_msg_i) begin
            flags_nxt[`CSIF_BIT_IVR] = 1'b1;
         end
         if (|(state_now & ~state_prev_r)) begin
            flags_nxt[`CSIF_BIT_ERR] = 1'b1;
         end
         if (store_ok && (fifo_occ_r + 6'd2 >= fifo_cap)) begin
            flags_nxt[`CSIF_BIT_FIFO] = 1'b1;
         end
         if (rx_overflow_i || store_bad) begin
            flags_nxt[`CSIF_BIT_RBOV] = 1'b1;
         end
         if (rx_buf_event_i) begin
            flags_nxt[`CSIF_BIT_RXB] = 1'b1;
         end
         if (tx_buf_event_i) begin
            flags_nxt[`CSIF_BIT_TB] = 1'b1;
         end
      end
      // bit 4 never holds a value
      flags_nxt = flags_nxt & `CSIF_FLAG_MASK;
   end

   // ----------------------------------------------------------------
   // per-buffer pending bits behind the code
   // ----------------------------------------------------------------
   // cleared together with the rx or tx summary flag
   always @* begin
      buf_pend_nxt = buf_pend_r;
      if (wr_flags && !wr_data_i[`CSIF_BIT_TB]) begin
         buf_pend_nxt[7:0] = 8'h00;
      end
      if (wr_flags && !wr_data_i[`CSIF_BIT_RXB]) begin
         buf_pend_nxt[15:0] = buf_pend_nxt[15:0] & {8'h00, 8'hff};
         buf_pend_nxt[7:0] = wr_data_i[`CSIF_BIT_TB] ? buf_pend_nxt[7:0] : 8'h00;
      end
      if (live && tx_buf_event_i) begin
         buf_pend_nxt[{1'b0, tx_buf_index_i}] = 1'b1;
      end
      if (live && rx_buf_event_i) begin
         buf_pend_nxt[rx_buf_index_i] = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // interrupt code priority
   // ----------------------------------------------------------------
   // error, wake, overflow, fifo, then lowest buffer
   always @* begin
      pending_source_code_nxt = `CSIF_CODE_NONE;
      for (i = 15; i >= 0; i = i - 1) begin
         if (buf_pend_r[i]) begin
            pending_source_code_nxt = i[6:0];
         end
      end
      if (flags_r[`CSIF_BIT_FIFO]) begin
         pending_source_code_nxt = `CSIF_CODE_FIFO;
      end
      if (flags_r[`CSIF_BIT_RBOV]) begin
         pending_source_code_nxt = `CSIF_CODE_OVF;
      end
      if (flags_r[`CSIF_BIT_WAKE]) begin
         pending_source_code_nxt = `CSIF_CODE_WAKE;
      end
      if (flags_r[`CSIF_BIT_ERR]) begin
         pending_source_code_nxt = `CSIF_CODE_ERR;
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         dnc_r <= `CSIF_RST_DNC;
         matched_filter_number_r <= `CSIF_RST_HITNUM;
         pending_source_code_r <= `CSIF_CODE_NONE;
         dma_buffer_count_select_r <= `CSIF_RST_SIZE;
         fifo_start_buffer_r <= `CSIF_RST_START;
         fifo_write_pointer_r <= `CSIF_RST_PTR;
         fifo_read_pointer_r <= `CSIF_RST_PTR;
         fifo_occ_r <= `CSIF_RST_PTR;
         state_r <= `CSIF_RST_STATE;
         state_prev_r <= `CSIF_RST_STATE;
         flags_r <= `CSIF_RST_FLAGS;
         en_r <= `CSIF_RST_EN;
         buf_pend_r <= 16'h0000;
      end else begin
         dnc_r <= data_byte_compare_count_i;
         // reserved hit numbers are not latched
         if (filter_hit_valid_i && filter_hit_i <= `CSIF_HITNUM_MAX) begin
            matched_filter_number_r <= filter_hit_i;
         end
         pending_source_code_r <= pending_source_code_nxt;
         // warnings, bit 8 is either side
         state_r <= state_now;
         state_prev_r <= state_now;
         flags_r <= flags_nxt;
         buf_pend_r <= buf_pend_nxt;
         if (wr_i && addr_i == `CSIF_ADDR_ENABLES) begin
            en_r <= wr_data_i[7:0] & `CSIF_FLAG_MASK;
         end
         if (wr_fifoctl && wr_data_i[15:13] != `CSIF_SIZE_RSVD) begin
            dma_buffer_count_select_r <= wr_data_i[15:13];
         end
         if (wr_fifoctl) begin
            fifo_start_buffer_r <= wr_data_i[4:0];
            fifo_write_pointer_r <= {1'b0, wr_data_i[4:0]};
            fifo_read_pointer_r <= {1'b0, wr_data_i[4:0]};
            fifo_occ_r <= 6'h00;
         end else begin
            if (store_ok) begin
               if (fifo_write_pointer_r == fifo_last) begin
                  fifo_write_pointer_r <= {1'b0, fifo_start_buffer_r};
               end else begin
                  fifo_write_pointer_r <= fifo_write_pointer_r + 6'd1;
               end
            end
            if (read_ok) begin
               if (fifo_read_pointer_r == fifo_last) begin
                  fifo_read_pointer_r <= {1'b0, fifo_start_buffer_r};
               end else begin
                  fifo_read_pointer_r <= fifo_read_pointer_r + 6'd1;
               end
            end
            if (store_ok && !read_ok) begin
               fifo_occ_r <= fifo_occ_r + 6'd1;
            end else if (!store_ok && read_ok) begin
               fifo_occ_r <= fifo_occ_r - 6'd1;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // filter compare and engine-facing outputs
   // ----------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         data_compare_en_o <= 1'b0;
         data_compare_bits_o <= 5'h00;
         dnc_invalid_o <= 1'b0;
         dma_buffer_count_o <= 6'd4;
         fifo_start_buffer_o <= `CSIF_RST_START;
         fifo_write_pointer_o <= `CSIF_RST_PTR;
         fifo_store_ok_o <= 1'b0;
         irq_o <= 1'b0;
      end else begin
         data_compare_en_o <= (dnc_r != 5'h00) && (dnc_r <= `CSIF_DNC_MAX);
         data_compare_bits_o <= (dnc_r <= `CSIF_DNC_MAX) ? dnc_r : 5'h00;
         dnc_invalid_o <= (dnc_r > `CSIF_DNC_MAX);
         dma_buffer_count_o <= dma_count;
         fifo_start_buffer_o <= fifo_start_buffer_r;
         fifo_write_pointer_o <= fifo_write_pointer_r;
         fifo_store_ok_o <= store_ok;
         irq_o <= |(flags_r & en_r);
      end
   end

   // ----------------------------------------------------------------
   // register read
   // ----------------------------------------------------------------
   // unused positions are zero in every word
   always @* begin
      rd_mux = {DATA_W{1'b0}};
      case (addr_i)
         `CSIF_ADDR_FILTCTL: rd_mux[4:0] = dnc_r;
         `CSIF_ADDR_VECTOR: begin
            rd_mux[12:8] = matched_filter_number_r;
            rd_mux[6:0] = pending_source_code_r;
         end
         `CSIF_ADDR_FIFOCTL: begin
            rd_mux[15:13] = dma_buffer_count_select_r;
            rd_mux[4:0] = fifo_start_buffer_r;
         end
         `CSIF_ADDR_FIFOSTAT: begin
            rd_mux[13:8] = fifo_write_pointer_r;
            rd_mux[5:0] = fifo_read_pointer_r;
         end
         `CSIF_ADDR_FLAGS: begin
            rd_mux[13:8] = state_r;
            rd_mux[7:0] = flags_r;
         end
         `CSIF_ADDR_ENABLES: rd_mux[7:0] = en_r;
         default: rd_mux = {DATA_W{1'b0}};
      endcase
   end

   // data valid only in the cycle after the strobe
   always @(posedge clk_i) begin
      if (rst_i) begin
         rd_data_o <= {DATA_W{1'b0}};
      end else if (rd_i) begin
         rd_data_o <= rd_mux;
      end else begin
         rd_data_o <= {DATA_W{1'b0}};
      end
   end

endmodule

// File: tb/can_status_interrupt_fifo_regs_bench.sv
module can_status_interrupt_fifo_regs_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst = 1, wr = 0, rd = 0, can_rx = 1, dis = 0, fh_v = 0, tx_ev = 0;
   logic rx_ev = 0, inv = 0, ovf = 0, st = 0, frd = 0, irq, cmp_en, cnt_bad, st_ok;
   logic [2:0] addr = 0, tx_idx = 0;
   logic [3:0] rx_idx = 0;
   logic [4:0] cnt = 0, fh = 0, sv = 0, cmp_bits, start_buf, cv;
   logic [5:0] dma_cnt, wptr, p;
   logic [15:0] wdata = 0, rdata;
   logic [5:0] sz [0:7] = '{6'h04, 6'h06, 6'h08, 6'h0c, 6'h10, 6'h18, 6'h20, 6'h20};
   int bad_count = 0, num_checks = 0;

   csif_regs dut (.clk_i(clk), .rst_i(rst), .addr_i(addr), .wr_data_i(wdata), .wr_i(wr),
      .rd_i(rd), .rd_data_o(rdata), .can_rx_i(can_rx), .disable_mode_i(dis),
      .data_byte_compare_count_i(cnt), .filter_hit_valid_i(fh_v), .filter_hit_i(fh),
      .tx_buf_event_i(tx_ev), .tx_buf_index_i(tx_idx), .rx_buf_event_i(rx_ev),
      .rx_buf_index_i(rx_idx), .invalid_msg_i(inv), .rx_overflow_i(ovf),
      .fifo_store_i(st), .fifo_read_i(frd), .tx_bus_off_i(sv[4]), .tx_err_passive_i(sv[3]),
      .rx_err_passive_i(sv[2]), .tx_warn_i(sv[1]), .rx_warn_i(sv[0]), .irq_o(irq),
      .data_compare_en_o(cmp_en), .data_compare_bits_o(cmp_bits), .dnc_invalid_o(cnt_bad),
      .dma_buffer_count_o(dma_cnt), .fifo_start_buffer_o(start_buf),
      .fifo_write_pointer_o(wptr), .fifo_store_ok_o(st_ok));

   // -------------------------------------------------
   // clock, bus tasks and verdict
   // -------------------------------------------------
   initial forever #5 clk = ~clk;

   task chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   task wr_reg(input logic [2:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // data stand only in the cycle after the strobe, so sample just past that edge
   task rd_chk(input logic [2:0] a, input logic [15:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, e);
   endtask

   task cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   task give_verdict;
      if (bad_count == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // the whole run needs well under a thousand cycles
   initial begin
      cyc(5000);
      bad_count++;
      give_verdict;
   end

   // -------------------------------------------------
   // test sequence
   // -------------------------------------------------
   initial begin
      cyc(3);
      rst <= 1'b0;
      for (int a = 0; a < 8; a++) rd_chk(3'(a), a == 1 ? 16'h0040 : 16'h0000);
      chk({10'h000, dma_cnt}, 16'h0004);
      wr_reg(3'h5, 16'hffff);
      rd_chk(3'h5, 16'h00ef);
      wr_reg(3'h5, 16'h0000);
      // compare count boundaries 0, 1, 17, 18 and 31; 18 and up are invalid
      foreach (sz[i]) begin
         cv = 5'(i == 0 ? 0 : i == 7 ? 31 : i == 6 ? 18 : i * 4 - 3);
         @(posedge clk);
         cnt <= cv;
         rd_chk(3'h0, {11'h000, cv});
         chk({cmp_en, cnt_bad, 9'h000, cmp_bits}, {cv inside {[1:17]}, cv > 17, 9'h000,
            cv > 17 ? 5'h00 : cv});
      end
      // every size code, reserved bits written as ones
      for (int c = 0; c < 8; c++) begin
         wr_reg(3'h2, {3'(c), 8'hff, 5'(c)});
         rd_chk(3'h2, {c == 7 ? 3'h6 : 3'(c), 8'h00, 5'(c)});
         chk({dma_cnt, 5'h00, start_buf}, {sz[c], 5'h00, 5'(c)});
      end
      // start 1 of four buffers holds three; the fourth store overflows
      wr_reg(3'h2, 16'h0001);
      p = 6'h01;
      for (int k = 1; k < 5; k++) begin
         @(posedge clk);
         st <= 1'b1;
         @(posedge clk);
         st <= 1'b0;
         #1 chk({15'h0000, st_ok}, {15'h0000, k < 4});
         if (k < 4) p = (p == 6'h03) ? 6'h01 : p + 6'h01;
         rd_chk(3'h3, {2'b00, p, 8'h01});
         chk({10'h000, wptr}, {10'h000, p});
      end
      rd_chk(3'h4, 16'h000c);
      rd_chk(3'h1, 16'h0043);
      @(posedge clk);
      frd <= 1'b1;
      @(posedge clk);
      frd <= 1'b0;
      rd_chk(3'h3, 16'h0102);
      wr_reg(3'h4, 16'h0000);
      rd_chk(3'h4, 16'h0000);
      // invalid message: software writes ones without effect, zero clears
      wr_reg(3'h5, 16'h0080);
      @(posedge clk);
      {inv, ovf} <= 2'b11;
      @(posedge clk);
      {inv, ovf} <= 2'b00;
      wr_reg(3'h4, 16'hffff);
      rd_chk(3'h4, 16'h0084);
      chk({15'h0000, irq}, 16'h0001);
      rd_chk(3'h1, 16'h0043);
      wr_reg(3'h4, 16'h007b);
      rd_chk(3'h4, 16'h0000);
      chk({15'h0000, irq}, 16'h0000);
      // filter hit 16 is reserved and must not replace 15
      @(posedge clk);
      {fh_v, fh, tx_ev, tx_idx, rx_ev, rx_idx} <= {1'b1, 5'h0f, 1'b1, 3'h7, 1'b1, 4'h9};
      @(posedge clk);
      {fh, tx_ev, rx_ev} <= {5'h10, 1'b0, 1'b0};
      @(posedge clk);
      fh_v <= 1'b0;
      rd_chk(3'h1, 16'h0f07);
      rd_chk(3'h4, 16'h0003);
      wr_reg(3'h4, 16'hfffe);
      rd_chk(3'h1, 16'h0f09);
      wr_reg(3'h4, 16'h0000);
      // one error state at a time
      for (int i = 0; i < 5; i++) begin
         @(posedge clk);
         sv <= 5'h10 >> i;
         cyc(3);
         rd_chk(3'h4, {2'b00, sv, sv[1] | sv[0], 8'h20});
         rd_chk(3'h1, 16'h0f41);
         @(posedge clk);
         sv <= 5'h00;
         wr_reg(3'h4, 16'h0000);
      end
      // disable mode: bus activity still wakes, other sources ignored
      wr_reg(3'h5, 16'h0040);
      @(posedge clk);
      {dis, inv, can_rx} <= 3'b110;
      @(posedge clk);
      inv <= 1'b0;
      cyc(6);
      rd_chk(3'h4, 16'h0040);
      rd_chk(3'h1, 16'h0f42);
      chk({15'h0000, irq}, 16'h0001);
      @(posedge clk);
      {dis, can_rx} <= 2'b01;
      wr_reg(3'h5, 16'h0000);
      cyc(2);
      #1 chk({15'h0000, irq}, 16'h0000);
      give_verdict;
   end
endmodule

bind csif_regs csif_regs_asserts chk_i (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
   .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
   .data_byte_compare_count_i(data_byte_compare_count_i), .fifo_store_i(fifo_store_i),
   .irq_o(irq_o), .data_compare_en_o(data_compare_en_o),
   .data_compare_bits_o(data_compare_bits_o), .dnc_invalid_o(dnc_invalid_o),
   .dma_buffer_count_o(dma_buffer_count_o), .fifo_start_buffer_o(fifo_start_buffer_o),
   .fifo_store_ok_o(fifo_store_ok_o));

// File: tb/csif_regs_asserts.sv
module csif_regs_asserts (
   input wire clk_i,
   input wire rst_i,
   input wire [2:0] addr_i,
   input wire [15:0] wr_data_i,
   input wire wr_i,
   input wire rd_i,
   input wire [15:0] rd_data_o,
   input wire [4:0] data_byte_compare_count_i,
   input wire fifo_store_i,
   input wire irq_o,
   input wire data_compare_en_o,
   input wire [4:0] data_compare_bits_o,
   input wire dnc_invalid_o,
   input wire [5:0] dma_buffer_count_o,
   input wire [4:0] fifo_start_buffer_o,
   input wire fifo_store_ok_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // size code to buffer count, codes 6 and 7 both give 32
   function automatic logic [5:0] size_of(input logic [2:0] c);
      case (c)
         3'h0: size_of = 6'h04;
         3'h1: size_of = 6'h06;
         3'h2: size_of = 6'h08;
         3'h3: size_of = 6'h0c;
         3'h4: size_of = 6'h10;
         3'h5: size_of = 6'h18;
         default: size_of = 6'h20;
      endcase
   endfunction

   // -------------------------------------------------
   // bus, decode and interrupt relations
   // -------------------------------------------------
   // data stand only in the cycle after a read strobe
   a_rdata_idle: assert property (!$past(rd_i) |-> rd_data_o == 16'h0000)
      else $error("read data not zero outside a read");
   a_unmapped_zero: assert property (rd_i && addr_i > 3'h5 |=> rd_data_o == 16'h0000)
      else $error("unmapped address read nonzero");
   a_count_mirror: assert property (
      rd_i && addr_i == 3'h0 && $stable(data_byte_compare_count_i)
      |=> rd_data_o == {11'h000, $past(data_byte_compare_count_i)})
      else $error("compare count read back wrong");
   a_compare_on: assert property (
      $stable(data_byte_compare_count_i) |=> data_compare_en_o
      == ($past(data_byte_compare_count_i) inside {[5'h01:5'h11]}))
      else $error("compare enable wrong for count");
   a_count_invalid: assert property (
      $stable(data_byte_compare_count_i) |=>
      dnc_invalid_o == ($past(data_byte_compare_count_i) > 5'h11) &&
      data_compare_bits_o == (($past(data_byte_compare_count_i) > 5'h11) ? 5'h00 :
      $past(data_byte_compare_count_i)))
      else $error("invalid count or compare bits wrong");
   a_size_decode: assert property (
      wr_i && addr_i == 3'h2 && wr_data_i[15:13] != 3'h7 ##1 !(wr_i && addr_i == 3'h2)
      |=> dma_buffer_count_o == size_of($past(wr_data_i[15:13], 2)))
      else $error("buffer count decode wrong");
   a_size_keep: assert property (
      wr_i && addr_i == 3'h2 && wr_data_i[15:13] == 3'h7 ##1 !(wr_i && addr_i == 3'h2)
      |=> $stable(dma_buffer_count_o))
      else $error("reserved size code changed count");
   a_start_write: assert property (
      wr_i && addr_i == 3'h2 ##1 !(wr_i && addr_i == 3'h2)
      |=> fifo_start_buffer_o == $past(wr_data_i[4:0], 2))
      else $error("fifo start not taken from write");
   a_store_cause: assert property (fifo_store_ok_o |-> $past(fifo_store_i))
      else $error("store accepted without request");
   a_irq_off: assert property (
      wr_i && addr_i == 3'h5 && wr_data_i[7:0] == 8'h00 ##1 !(wr_i && addr_i == 3'h5)
      |=> !irq_o)
      else $error("interrupt request with all enables off");
endmodule
